// ### hw/ipc_pkg.sv
// Purpose: Shared constants and carriers of the interrupt priority block
// Assumes: APB byte addressing, one register per word, 8-bit registers in the low byte
// Notes:   Offsets are byte addresses
package ipc_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFS_NET_PRIO  = 8'h00;
	localparam logic [7:0] OFS_RST_CAUSE = 8'h04;
	localparam logic [7:0] OFS_IRQ_CTL1  = 8'h08;
	localparam logic [7:0] OFS_IRQ_CTL2  = 8'h0C;
	localparam logic [7:0] OFS_IRQ_CTL3  = 8'h10;
	localparam logic [7:0] OFS_BLOCK_CFG = 8'h14;
	localparam logic [7:0] OFS_TMR_LOW   = 8'h18;
	localparam logic [7:0] OFS_TMR_HIGH  = 8'h1C;
	localparam logic [7:0] OFS_CONTEXT   = 8'h20;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_PRIORITY_LEVELS_ENABLE     = 7;
	localparam int BIT_SOFT_BROWNOUT_ENABLE   = 6;
	localparam int BIT_RI       = 4;
	localparam int BIT_TO       = 3;
	localparam int BIT_PD       = 2;
	localparam int BIT_POR      = 1;
	localparam int BIT_BOR      = 0;
	localparam int BIT_GIE      = 7;
	localparam int BIT_GIEL     = 6;
	localparam int BIT_T0_EN    = 5;
	localparam int BIT_X0_EN    = 4;
	localparam int BIT_RB_EN    = 3;
	localparam int BIT_T0_FLAG  = 2;
	localparam int BIT_X0_FLAG  = 1;
	localparam int BIT_RB_FLAG  = 0;
	localparam int BIT_EDGE0    = 6;
	localparam int BIT_T0_PRIO  = 2;
	localparam int BIT_RB_PRIO  = 0;
	localparam int BIT_X2_PRIO  = 7;
	localparam int BIT_X1_PRIO  = 6;
	localparam int BIT_X2_EN    = 4;
	localparam int BIT_X1_EN    = 3;
	localparam int BIT_X2_FLAG  = 1;
	localparam int BIT_X1_FLAG  = 0;
	localparam int BIT_T0_RUN   = 2;
	localparam int BIT_T0_WIDE  = 3;
	// ****************************************
	// Reset values, masks and sizes
	// ****************************************
	localparam logic [7:0] RST_NET_PRIO  = 8'hFF;
	localparam logic [7:0] RST_RST_CAUSE = 8'h1C;
	localparam logic [7:0] MASK_RST_WR   = 8'hD1;
	localparam logic [1:0] CAN_MODE0     = 2'h0;
	localparam logic [1:0] CAN_MODE1     = 2'h1;
	localparam logic [7:0] MASK_MODE12   = 8'hF3;
	localparam logic [7:0] MASK_MODE1    = 8'hF2;
	localparam int         STACK_DEPTH   = 4;
	localparam logic [7:0] DATA_ZERO     = 8'h00;
	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic        irq_take;
		logic        fast_ret;
		logic        sleeping;
		logic [20:0] pc;
		logic [7:0]  working_register;
		logic [7:0]  status;
		logic [7:0]  bank_select_register;
	} ipc_core_in_s;
	typedef struct packed {
		logic        irq_high;
		logic        irq_low;
		logic        wake;
		logic [20:0] stack_top;
		logic [7:0]  working_register;
		logic [7:0]  status;
		logic [7:0]  bank_select_register;
	} ipc_core_out_s;
endpackage

// ### hw/ipc_top.sv
// Purpose: Interrupt priority, sources and context saving
// Assumes: APB master, single clock, core gives take pulses
// Notes:   pready answers one cycle after setup
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module ipc_top
	import ipc_pkg::*;
(
	input  wire logic          clock,
	input  wire logic          rst_n,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic               pready,
	output logic [31:0]        prdata,
	output logic               pslverr,
	input  wire logic [2:0]    ext_pin,
	input  wire logic [3:0]    second_io_port,
	input  wire logic [7:0]    can_irq,
	input  wire logic          soft_bor_strap,
	input  wire logic          power_on_kind,
	input  wire ipc_core_in_s  core_in,
	output ipc_core_out_s      core_out
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic                               boot;
		logic                               rdy;
		logic                               err;
		logic [7:0]                         rdata;
		logic [7:0]                         net_prio;
		logic [7:0]                         rst_cause;
		logic [7:0]                         ctl1;
		logic [7:0]                         ctl2;
		logic [7:0]                         ctl3;
		logic [7:0]                         cfg;
		logic [15:0]                        tmr;
		logic [2:0]                         x_s1;
		logic [2:0]                         x_s2;
		logic [2:0]                         x_s3;
		logic [3:0]                         p_s1;
		logic [3:0]                         p_s2;
		logic [3:0]                         p_s3;
		logic [2:0]                         settle;
		logic [STACK_DEPTH-1:0][20:0]       stk;
		logic [1:0]                         sp;
		ipc_core_out_s                      out;
	} ipc_state_s;

	ipc_state_s st_q;
	ipc_state_s st_d;
	logic [2:0] ext_edge;
	logic [7:0] can_hi;
	logic [7:0] can_lo;
	logic [7:0] prio_eff;
	logic       acc;
	logic       wr;
	logic       mapped;
	logic [7:0] wb;
	logic       priority_levels_enable;
	logic       hi_req;
	logic       lo_req;

	// ****************************************
	// Pin edges
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_edge
			// Selected polarity only
			assign ext_edge[g] = st_q.ctl2[BIT_EDGE0-g] ? (st_q.x_s2[g] & ~st_q.x_s3[g])
				: (~st_q.x_s2[g] & st_q.x_s3[g]);
		end
	endgenerate

	assign acc    = psel & penable & st_q.rdy;
	assign wr     = acc & pwrite;
	assign wb     = pwdata[7:0];
	assign priority_levels_enable   = st_q.rst_cause[BIT_PRIORITY_LEVELS_ENABLE];
	assign mapped = (paddr == OFS_NET_PRIO) || (paddr == OFS_RST_CAUSE) || (paddr == OFS_IRQ_CTL1)
		|| (paddr == OFS_IRQ_CTL2) || (paddr == OFS_IRQ_CTL3) || (paddr == OFS_BLOCK_CFG)
		|| (paddr == OFS_TMR_LOW) || (paddr == OFS_TMR_HIGH) || (paddr == OFS_CONTEXT);

	// ****************************************
	// Priority routing
	// ****************************************
	always_comb
	begin
		prio_eff = st_q.net_prio;
		if (st_q.cfg[1:0] == CAN_MODE1)
			prio_eff = st_q.net_prio & MASK_MODE1;
		else if (st_q.cfg[1:0] != CAN_MODE0)
			prio_eff = st_q.net_prio & MASK_MODE12;
		// Single level when priorities off
		can_hi = priority_levels_enable ? (can_irq & prio_eff) : can_irq;
		can_lo = priority_levels_enable ? (can_irq & ~prio_eff) : DATA_ZERO;
		hi_req = (|can_hi)
			| (st_q.ctl1[BIT_X0_FLAG] & st_q.ctl1[BIT_X0_EN])
			| (st_q.ctl1[BIT_T0_FLAG] & st_q.ctl1[BIT_T0_EN] & (~priority_levels_enable | st_q.ctl2[BIT_T0_PRIO]))
			| (st_q.ctl1[BIT_RB_FLAG] & st_q.ctl1[BIT_RB_EN] & (~priority_levels_enable | st_q.ctl2[BIT_RB_PRIO]))
			| (st_q.ctl3[BIT_X1_FLAG] & st_q.ctl3[BIT_X1_EN] & (~priority_levels_enable | st_q.ctl3[BIT_X1_PRIO]))
			| (st_q.ctl3[BIT_X2_FLAG] & st_q.ctl3[BIT_X2_EN] & (~priority_levels_enable | st_q.ctl3[BIT_X2_PRIO]));
		lo_req = priority_levels_enable & ((|can_lo)
			| (st_q.ctl1[BIT_T0_FLAG] & st_q.ctl1[BIT_T0_EN] & ~st_q.ctl2[BIT_T0_PRIO])
			| (st_q.ctl1[BIT_RB_FLAG] & st_q.ctl1[BIT_RB_EN] & ~st_q.ctl2[BIT_RB_PRIO])
			| (st_q.ctl3[BIT_X1_FLAG] & st_q.ctl3[BIT_X1_EN] & ~st_q.ctl3[BIT_X1_PRIO])
			| (st_q.ctl3[BIT_X2_FLAG] & st_q.ctl3[BIT_X2_EN] & ~st_q.ctl3[BIT_X2_PRIO]));
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		st_d = st_q;
		st_d.boot = 1'b0;
		// Synchronisers
		st_d.x_s1 = ext_pin;
		st_d.x_s2 = st_q.x_s1;
		st_d.x_s3 = st_q.x_s2;
		st_d.p_s1 = second_io_port;
		st_d.p_s2 = st_q.p_s1;
		st_d.p_s3 = st_q.p_s2;
		st_d.settle = {st_q.settle[1:0], 1'b1};
		// Straps caught after release
		if (st_q.boot)
		begin
			st_d.rst_cause[BIT_SOFT_BROWNOUT_ENABLE] = soft_bor_strap;
			st_d.rst_cause[BIT_POR]    = power_on_kind;
		end
		// APB answer
		st_d.rdy   = psel & ~penable;
		st_d.err   = psel & ~penable & ~mapped;
		st_d.rdata = DATA_ZERO;
		if (psel & ~penable & ~pwrite)
		begin
			unique case (paddr)
				OFS_NET_PRIO:  st_d.rdata = prio_eff;
				OFS_RST_CAUSE: st_d.rdata = st_q.rst_cause;
				OFS_IRQ_CTL1:  st_d.rdata = st_q.ctl1;
				OFS_IRQ_CTL2:  st_d.rdata = st_q.ctl2;
				OFS_IRQ_CTL3:  st_d.rdata = st_q.ctl3;
				OFS_BLOCK_CFG: st_d.rdata = st_q.cfg;
				OFS_TMR_LOW:   st_d.rdata = st_q.tmr[7:0];
				OFS_TMR_HIGH:  st_d.rdata = st_q.tmr[15:8];
				OFS_CONTEXT:   st_d.rdata = {6'h00, st_q.sp};
				default:       st_d.rdata = DATA_ZERO;
			endcase
		end
		// Register writes
		if (wr)
		begin
			unique case (paddr)
				OFS_NET_PRIO:  st_d.net_prio = wb;
				OFS_RST_CAUSE: st_d.rst_cause = (st_q.rst_cause & ~MASK_RST_WR) | (wb & MASK_RST_WR);
				OFS_IRQ_CTL1:  st_d.ctl1 = wb;
				OFS_IRQ_CTL2:  st_d.ctl2 = wb;
				OFS_IRQ_CTL3:  st_d.ctl3 = wb;
				OFS_BLOCK_CFG: st_d.cfg = wb;
				OFS_TMR_LOW:   st_d.tmr[7:0] = wb;
				OFS_TMR_HIGH:  st_d.tmr[15:8] = wb;
				default:       st_d.cfg = st_q.cfg;
			endcase
		end
		// Mode forces bits low
		if (st_d.cfg[1:0] == CAN_MODE1)
			st_d.net_prio = st_d.net_prio & MASK_MODE1;
		else if (st_d.cfg[1:0] != CAN_MODE0)
			st_d.net_prio = st_d.net_prio & MASK_MODE12;
		// Timer, set wins over clear
		if (st_q.cfg[BIT_T0_RUN] && !(wr && (paddr == OFS_TMR_LOW || paddr == OFS_TMR_HIGH)))
		begin
			if (st_q.cfg[BIT_T0_WIDE])
				st_d.tmr = st_q.tmr + 16'h0001;
			else
				st_d.tmr[7:0] = st_q.tmr[7:0] + 8'h01;
			if (st_q.cfg[BIT_T0_WIDE] ? (st_q.tmr == 16'hFFFF) : (st_q.tmr[7:0] == 8'hFF))
				st_d.ctl1[BIT_T0_FLAG] = 1'b1;
		end
		// Pin flags
		if (ext_edge[0])
			st_d.ctl1[BIT_X0_FLAG] = 1'b1;
		if (ext_edge[1])
			st_d.ctl3[BIT_X1_FLAG] = 1'b1;
		if (ext_edge[2])
			st_d.ctl3[BIT_X2_FLAG] = 1'b1;
		// Port change, quiet until chain filled
		if (st_q.settle[2] && (st_q.p_s2 != st_q.p_s3))
			st_d.ctl1[BIT_RB_FLAG] = 1'b1;
		// Request outputs gated by global enables, wake is not
		st_d.out.irq_high = hi_req & st_q.ctl1[BIT_GIE] & ~core_in.irq_take;
		st_d.out.irq_low  = lo_req & st_q.ctl1[BIT_GIE] & st_q.ctl1[BIT_GIEL] & ~core_in.irq_take;
		st_d.out.wake = core_in.sleeping & ((st_q.ctl1[BIT_X0_FLAG] & st_q.ctl1[BIT_X0_EN])
			| (st_q.ctl3[BIT_X1_FLAG] & st_q.ctl3[BIT_X1_EN])
			| (st_q.ctl3[BIT_X2_FLAG] & st_q.ctl3[BIT_X2_EN]));
		// Context save and stack
		if (core_in.irq_take)
		begin
			st_d.stk[st_q.sp]               = core_in.pc;
			st_d.sp                         = st_q.sp + 2'h1;
			st_d.out.stack_top              = core_in.pc;
			st_d.out.working_register       = core_in.working_register;
			st_d.out.status                 = core_in.status;
			st_d.out.bank_select_register   = core_in.bank_select_register;
		end
		else if (core_in.fast_ret)
		begin
			st_d.sp            = st_q.sp - 2'h1;
			st_d.out.stack_top = st_q.stk[st_q.sp - 2'h2];
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q           <= '0;
			st_q.boot      <= 1'b1;
			st_q.net_prio  <= RST_NET_PRIO;
			st_q.rst_cause <= RST_RST_CAUSE;
		end
		else
			st_q <= st_d;
	end

	assign pready   = st_q.rdy;
	assign pslverr  = st_q.err;
	assign prdata   = {24'h000000, st_q.rdata};
	assign core_out = st_q.out;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	chk_mode1_bit0: assert property ((st_q.cfg[1:0] == CAN_MODE1) |-> !st_q.net_prio[0])
		else $error("Mode 1 bit 0 not zero");
	chk_mode12_tx: assert property ((st_q.cfg[1:0] != CAN_MODE0) |-> st_q.net_prio[3:2] == 2'h0)
		else $error("Tx priority bits not held low");
	chk_single_level: assert property (!priority_levels_enable |=> !core_out.irq_low)
		else $error("Low request without priority levels");
	chk_can_route: assert property (priority_levels_enable && can_irq[7] && !st_q.net_prio[7] && st_q.ctl1[BIT_GIE]
		&& st_q.ctl1[BIT_GIEL] && !core_in.irq_take |=> core_out.irq_low)
		else $error("Invalid message not routed low");
	chk_edge_flag: assert property (ext_edge[1] |=> st_q.ctl3[BIT_X1_FLAG])
		else $error("Edge did not set flag");
	chk_pin_rise: assert property (st_q.ctl2[BIT_EDGE0] && $rose(st_q.x_s2[0]) |-> ext_edge[0])
		else $error("Rising edge missed");
	chk_tmr_wrap: assert property (st_q.cfg[BIT_T0_RUN] && !st_q.cfg[BIT_T0_WIDE] && st_q.tmr[7:0] == 8'hFF
		&& !wr |=> st_q.ctl1[BIT_T0_FLAG] && st_q.tmr[7:0] == 8'h00)
		else $error("Timer wrap not flagged");
	chk_pin0_high: assert property (priority_levels_enable && st_q.ctl1[BIT_X0_FLAG] && st_q.ctl1[BIT_X0_EN]
		&& st_q.ctl1[BIT_GIE] && !core_in.irq_take |=> core_out.irq_high)
		else $error("Pin 0 not high priority");
	chk_wake_pin: assert property (core_in.sleeping && st_q.ctl1[BIT_X0_FLAG] && st_q.ctl1[BIT_X0_EN]
		|=> core_out.wake)
		else $error("No wake from pin");
	chk_ctx_save: assert property (core_in.irq_take |=> core_out.status == $past(core_in.status)
		&& core_out.stack_top == $past(core_in.pc))
		else $error("Context not saved");
	chk_port_change: assert property (st_q.settle[2] && (st_q.p_s2 != st_q.p_s3) |=> st_q.ctl1[BIT_RB_FLAG])
		else $error("Port change not flagged");
	chk_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("APB answer timing");
	chk_ro_flags: assert property (wr && (paddr == OFS_RST_CAUSE)
		|=> st_q.rst_cause[BIT_TO] == $past(st_q.rst_cause[BIT_TO])
		&& st_q.rst_cause[BIT_PD] == $past(st_q.rst_cause[BIT_PD])
		&& st_q.rst_cause[BIT_POR] == $past(st_q.rst_cause[BIT_POR])
		&& !st_q.rst_cause[BIT_SOFT_BROWNOUT_ENABLE-1])
		else $error("Read-only reset flag changed");
	chk_priority_levels_enable_write: assert property (wr && (paddr == OFS_RST_CAUSE) |=> priority_levels_enable == $past(wb[BIT_PRIORITY_LEVELS_ENABLE]))
		else $error("Priority enable not written");
	chk_prio_write: assert property (wr && (paddr == OFS_NET_PRIO) && (st_q.cfg[1:0] == CAN_MODE0)
		|=> st_q.net_prio == $past(wb))
		else $error("Priority byte not written");
	chk_strap_load: assert property (rst_n && st_q.boot
		|=> st_q.rst_cause[BIT_SOFT_BROWNOUT_ENABLE] == $past(soft_bor_strap)
		&& st_q.rst_cause[BIT_POR] == $past(power_on_kind))
		else $error("Strap values not loaded");
	chk_wide_wrap: assert property (st_q.cfg[BIT_T0_RUN] && st_q.cfg[BIT_T0_WIDE] && st_q.tmr == 16'hFFFF
		&& !wr |=> st_q.ctl1[BIT_T0_FLAG] && st_q.tmr == 16'h0000)
		else $error("Wide timer wrap not flagged");
	chk_timer_high: assert property (priority_levels_enable && st_q.ctl1[BIT_T0_FLAG] && st_q.ctl1[BIT_T0_EN]
		&& st_q.ctl2[BIT_T0_PRIO] && st_q.ctl1[BIT_GIE] && !core_in.irq_take
		|=> core_out.irq_high)
		else $error("Timer not routed high");
	chk_pin_fall: assert property (!st_q.ctl2[BIT_EDGE0-1] && $fell(st_q.x_s2[1]) |-> ext_edge[1])
		else $error("Falling edge missed");
	chk_pin1_low: assert property (priority_levels_enable && st_q.ctl3[BIT_X1_FLAG] && st_q.ctl3[BIT_X1_EN]
		&& !st_q.ctl3[BIT_X1_PRIO] && st_q.ctl1[BIT_GIE] && st_q.ctl1[BIT_GIEL]
		&& !core_in.irq_take |=> core_out.irq_low)
		else $error("Pin 1 not routed low");
	chk_high_gated: assert property (core_out.irq_high |-> $past(st_q.ctl1[BIT_GIE]))
		else $error("High request without global enable");

	cov_high_irq: cover property (core_out.irq_high ##1 core_in.irq_take);
	cov_low_irq: cover property (core_out.irq_low);
	cov_wide_wrap: cover property (st_q.cfg[BIT_T0_WIDE] && st_q.tmr == 16'hFFFF ##1 st_q.tmr == 16'h0000);
	cov_port_flag: cover property (st_q.ctl1[BIT_RB_FLAG] && st_q.ctl1[BIT_RB_EN]);
	cov_wake: cover property (core_out.wake);
endmodule
`default_nettype wire

// ### test/ipc_core_model.sv
// Purpose: Core stand-in that takes interrupt vectors
// Assumes: Take pulse follows a request after TAKE_DLY+1 cycles
// Notes:   Context values are fixed patterns
`timescale 1ns/10ps
`default_nettype none
module ipc_core_model
	import ipc_pkg::*;
#(
	parameter int TAKE_DLY = 3
)
(
	input  wire logic          clock,
	input  wire logic          rst_n,
	input  wire logic          sleep_req,
	input  wire ipc_core_out_s core_out,
	output ipc_core_in_s       core_in
);
	int cnt;
	// Takes each request, no fast return, context saved by ipc_top
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= 0;
			core_in <= '0;
		end
		else
		begin
			core_in.irq_take <= 1'h0;
			core_in.fast_ret <= 1'h0;
			core_in.sleeping <= sleep_req;
			core_in.pc <= 21'h0ABCD;
			core_in.working_register <= 8'h5A;
			core_in.status <= 8'hC3;
			core_in.bank_select_register <= 8'h0F;
			cnt <= 0;
			if ((core_out.irq_high || core_out.irq_low) && !core_in.irq_take)
				cnt <= cnt + 1;
			if (cnt == TAKE_DLY)
			begin
				core_in.irq_take <= 1'h1;
				cnt <= 0;
			end
		end
	end
endmodule
`default_nettype wire

// ### test/ipc_top_tb_top.sv
// Purpose: Self-checking bench of the interrupt block
// Assumes: APB slave answers within a bounded wait
// Notes:   Core side played by ipc_core_model
`timescale 1ns/10ps
`default_nettype none
module ipc_top_tb_top;
	import ipc_pkg::*;
	logic          clock;
	logic          rst_n;
	logic          psel;
	logic          penable;
	logic          pwrite;
	logic [7:0]    paddr;
	logic [31:0]   pwdata;
	logic          pready;
	logic [31:0]   prdata;
	logic          pslverr;
	logic [2:0]    ext_pin;
	logic [3:0]    second_io_port;
	logic [7:0]    can_irq;
	logic          sleep_req;
	ipc_core_in_s  core_in;
	ipc_core_out_s core_out;
	logic [31:0]   rd;
	logic          err;
	int            miscompares;
	int            tests_run;
	logic          soft_bor_strap;
	logic          power_on_kind;
	ipc_top ipc_top_inst (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .ext_pin, .second_io_port, .can_irq, .soft_bor_strap, .power_on_kind,
		.core_in, .core_out);
	ipc_core_model #(.TAKE_DLY(3)) ipc_core_model_inst (.clock, .rst_n, .sleep_req, .core_out, .core_in);
	initial
	begin
		clock = 1'h0;
		forever #10 clock = ~clock;
	end
	// ****
	// Tasks
	// ****
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clock);
		penable <= 1'h1;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'h1 && n < 20);
		if (n >= 20)
		begin
			miscompares++;
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'h1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		xfer(1'h0, a, 8'h00);
		check(64'(rd), 64'(exp));
	endtask
	task automatic wait_irq(input logic hi, input logic lo);
		int n;
		n = 0;
		while ({core_out.irq_high, core_out.irq_low} !== {hi, lo} && n < 40)
		begin
			@(posedge clock);
			n++;
		end
		check(64'({core_out.irq_high, core_out.irq_low}), 64'({hi, lo}));
		if ({core_out.irq_high, core_out.irq_low} !== {hi, lo})
			test_done();
	endtask
	task automatic wait_sig(input logic take);
		int n;
		n = 0;
		while ((take ? core_in.irq_take : core_out.wake) !== 1'h1 && n < 40)
		begin
			@(posedge clock);
			n++;
		end
		check(64'(take ? core_in.irq_take : core_out.wake), 64'h1);
		if ((take ? core_in.irq_take : core_out.wake) !== 1'h1)
			test_done();
	endtask
	// ****
	// Scenarios
	// ****
	task automatic test_regs;
		rdc(OFS_NET_PRIO, 8'hFF);
		rdc(OFS_RST_CAUSE, 8'h5E);
		wr(OFS_RST_CAUSE, 8'h00);
		rdc(OFS_RST_CAUSE, 8'h0E);
		wr(OFS_RST_CAUSE, 8'hFF);
		rdc(OFS_RST_CAUSE, 8'hDF);
		xfer(1'h0, 8'h30, 8'h00);
		check(64'({err, rd}), 64'h1_0000_0000);
		wr(OFS_NET_PRIO, 8'h00);
		rdc(OFS_NET_PRIO, 8'h00);
		wr(OFS_NET_PRIO, 8'hFF);
		wr(OFS_BLOCK_CFG, 8'h02);
		rdc(OFS_NET_PRIO, 8'hF3);
		wr(OFS_NET_PRIO, 8'hFF);
		rdc(OFS_NET_PRIO, 8'hF3);
		wr(OFS_BLOCK_CFG, 8'h01);
		rdc(OFS_NET_PRIO, 8'hF2);
		$display("register test done");
	endtask
	task automatic test_can;
		logic [7:0] base;
		wr(OFS_IRQ_CTL1, 8'hC0);
		for (int m = 0; m < 2; m++)
		begin
			base = m ? 8'hF2 : 8'hFF;
			wr(OFS_BLOCK_CFG, m ? 8'h01 : 8'h00);
			for (int b = 0; b < 8; b++)
			begin
				if (base[b])
				begin
					wr(OFS_NET_PRIO, base & ~(8'h01 << b));
					can_irq <= 8'h01 << b;
					wait_irq(1'h0, 1'h1);
					wr(OFS_NET_PRIO, base);
					wait_irq(1'h1, 1'h0);
					can_irq <= 8'h00;
					wait_irq(1'h0, 1'h0);
				end
			end
		end
		wr(OFS_RST_CAUSE, 8'h00);
		wr(OFS_NET_PRIO, 8'h72);
		can_irq <= 8'h80;
		wait_irq(1'h1, 1'h0);
		can_irq <= 8'h00;
		wait_irq(1'h0, 1'h0);
		$display("network priority test done");
	endtask
	task automatic test_pins;
		wr(OFS_RST_CAUSE, 8'h80);
		wr(OFS_IRQ_CTL2, 8'h50);
		wr(OFS_IRQ_CTL1, 8'hD0);
		ext_pin[0] <= 1'h1;
		wait_irq(1'h1, 1'h0);
		wait_sig(1'h1);
		@(posedge clock);
		@(posedge clock);
		check(64'({core_out.stack_top, core_out.working_register, core_out.status,
			core_out.bank_select_register}), 64'({21'h0ABCD, 8'h5A, 8'hC3, 8'h0F}));
		wr(OFS_IRQ_CTL1, 8'hC0);
		rdc(OFS_IRQ_CTL1, 8'hC0);
		wait_irq(1'h0, 1'h0);
		wr(OFS_IRQ_CTL1, 8'hD0);
		ext_pin[0] <= 1'h0;
		repeat (6) @(posedge clock);
		rdc(OFS_IRQ_CTL1, 8'hD0);
		wr(OFS_IRQ_CTL3, 8'h08);
		ext_pin[1] <= 1'h0;
		wait_irq(1'h0, 1'h1);
		wr(OFS_IRQ_CTL3, 8'h00);
		wait_irq(1'h0, 1'h0);
		wr(OFS_IRQ_CTL1, 8'h00);
		wr(OFS_IRQ_CTL3, 8'h10);
		sleep_req <= 1'h1;
		ext_pin[2] <= 1'h1;
		wait_sig(1'h0);
		check(64'({core_out.irq_high, core_out.irq_low}), 64'h0);
		wr(OFS_IRQ_CTL3, 8'h00);
		sleep_req <= 1'h0;
		$display("pin test done");
	endtask
	task automatic test_timer;
		wr(OFS_IRQ_CTL2, 8'h54);
		wr(OFS_IRQ_CTL1, 8'hA0);
		wr(OFS_BLOCK_CFG, 8'h09);
		wr(OFS_TMR_HIGH, 8'h00);
		wr(OFS_TMR_LOW, 8'hF8);
		wr(OFS_BLOCK_CFG, 8'h0D);
		repeat (12) @(posedge clock);
		rdc(OFS_IRQ_CTL1, 8'hA0);
		wr(OFS_BLOCK_CFG, 8'h09);
		wr(OFS_TMR_HIGH, 8'hFF);
		wr(OFS_TMR_LOW, 8'hF8);
		wr(OFS_BLOCK_CFG, 8'h0D);
		wait_irq(1'h1, 1'h0);
		wr(OFS_BLOCK_CFG, 8'h01);
		wr(OFS_IRQ_CTL1, 8'hA0);
		wait_irq(1'h0, 1'h0);
		wr(OFS_TMR_LOW, 8'hFC);
		wr(OFS_BLOCK_CFG, 8'h05);
		wait_irq(1'h1, 1'h0);
		wr(OFS_BLOCK_CFG, 8'h01);
		wr(OFS_IRQ_CTL1, 8'h80);
		$display("timer test done");
	endtask
	task automatic test_port;
		wr(OFS_IRQ_CTL2, 8'h55);
		wr(OFS_IRQ_CTL1, 8'h88);
		second_io_port <= 4'h8;
		wait_irq(1'h1, 1'h0);
		rdc(OFS_IRQ_CTL1, 8'h89);
		wr(OFS_IRQ_CTL1, 8'h80);
		wait_irq(1'h0, 1'h0);
		$display("port change test done");
	endtask
	task automatic test_reset;
		soft_bor_strap <= 1'h0;
		power_on_kind <= 1'h0;
		rst_n <= 1'h0;
		repeat (12) @(posedge clock);
		rst_n <= 1'h1;
		@(posedge clock);
		rdc(OFS_RST_CAUSE, 8'h1C);
		rdc(OFS_NET_PRIO, 8'hFF);
		rdc(OFS_IRQ_CTL1, 8'h00);
		$display("reset test done");
	endtask
	initial
	begin
		rst_n = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ext_pin = 3'h2;
		second_io_port = 4'h0;
		can_irq = 8'h00;
		sleep_req = 1'h0;
		soft_bor_strap = 1'h1;
		power_on_kind = 1'h1;
		miscompares = 0;
		tests_run = 0;
		repeat (12) @(posedge clock);
		rst_n <= 1'h1;
		@(posedge clock);
		test_regs();
		test_can();
		test_pins();
		test_timer();
		test_port();
		test_reset();
		test_done();
	end
endmodule
`default_nettype wire
